// >>> aicz_config0.v
// Interface configuration register 0 with direction check and write-pending control.
// Assumes the microcontroller bus is synchronous to mclk; the transfer engine
// and counters live outside and talk to this block by plain strobes.
// How it works
// - Power-up or watchdog reset clears; USB reset ignored
// - Bit 7 picks USB or storage byte counts
// - Bits 1:0 select PIO, multiword or Ultra DMA
// - Bit 2 enables ATAPI DMA direction check
// - Mismatch aborts transfer, sets direction error flag
// - Direction check ignored for ATA transfers
// - Hold last USB write packet for controller
// - Abort enable lets controller flush last packet
// - Abort disabled lets controller drain FIFO fully
// - Byte counts are 32 bits, low byte first
`timescale 1ns/1ps
`include "aicz_regs.vh"
module aicz_config0 (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        wdt_rst,
    input  wire        usb_bus_rst,
    input  wire [15:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        reg_hit,
    input  wire [31:0] usb_count,
    input  wire [31:0] ata_count,
    output wire [1:0]  transfer_protocol_field,
    input  wire        dma_phase_req,
    input  wire        xfer_is_atapi,
    input  wire        xfer_is_dma,
    input  wire        dev_dir_in,
    input  wire        bridge_dir_in,
    output wire        dma_phase_go,
    output reg         xfer_abort,
    output reg         direction_sequence_error_flag,
    input  wire        dseq_err_clr,
    input  wire        last_pkt_arrived,
    input  wire        mcu_resolve,
    output reg         write_pending_hold,
    output reg         flush_last_pkt,
    output reg         drain_fifo_all
);
    ////////////////////////////////////////////////////////////////////////
    reg  [7:0] cfg_q;
    wire [7:0] cfg_d;
    wire       cfg_sel = (reg_addr == `AICZ_CFG0_ADDR);
    wire       bc_sel  = (reg_addr >= `AICZ_BCNT0_ADDR) && (reg_addr <= `AICZ_BCNT3_ADDR);
    wire [15:0] bc_off = reg_addr - `AICZ_BCNT0_ADDR;
    wire [7:0] bc_byte;

    assign reg_hit = cfg_sel | bc_sel;
    // Reserved bits never stored, so they read as zero
    assign cfg_d = (reg_wdata & `AICZ_CFG0_WMASK) | (cfg_q & ~`AICZ_CFG0_WMASK);

    // usb_bus_rst deliberately unused by this register
    always @(posedge mclk) begin
        if (!rst_b || wdt_rst) begin
            cfg_q <= `AICZ_CFG0_RESET;
        end else if (reg_wr && cfg_sel) begin
            cfg_q <= cfg_d; // Bits 7 and 3:0 written in one go; firmware merges bits
        end
    end

    assign transfer_protocol_field = cfg_q[1:0];
    wire dir_chk_en  = cfg_q[`AICZ_BIT_DIRCHK];
    wire wp_abort_en = cfg_q[`AICZ_BIT_WPABORT];

    aicz_bcnt_mux #(
        .CW(32)
    ) u_mux (
        .usb_count(usb_count),
        .ata_count(ata_count),
        .view_sel (cfg_q[`AICZ_BIT_VIEW]),
        .byte_idx (bc_off[1:0]),
        .rd_byte  (bc_byte)
    );

    always @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (cfg_sel)
                reg_rdata <= cfg_q;
            else if (bc_sel)
                reg_rdata <= bc_byte;
            else
                reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction check applies to ATAPI DMA only; ATA never aborts
    wire chk_applies = dir_chk_en && xfer_is_atapi && xfer_is_dma;
    wire dir_bad     = chk_applies && (dev_dir_in != bridge_dir_in);
    assign dma_phase_go = dma_phase_req && !dir_bad;

    always @(posedge mclk) begin
        if (!rst_b) begin
            xfer_abort <= 1'b0;
            direction_sequence_error_flag <= 1'b0;
        end else begin
            xfer_abort <= dma_phase_req && dir_bad;
            // Set beats a clear in the same cycle
            if (dma_phase_req && dir_bad)
                direction_sequence_error_flag <= 1'b1;
            else if (dseq_err_clr)
                direction_sequence_error_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Last packet held until controller resolves; resolve picks flush or drain
    always @(posedge mclk) begin
        if (!rst_b) begin
            write_pending_hold <= 1'b0;
            flush_last_pkt     <= 1'b0;
            drain_fifo_all     <= 1'b0;
        end else begin
            flush_last_pkt <= 1'b0;
            drain_fifo_all <= 1'b0;
            if (write_pending_hold && mcu_resolve) begin
                write_pending_hold <= last_pkt_arrived; // New packet re-arms hold
                flush_last_pkt <= wp_abort_en;
                drain_fifo_all <= !wp_abort_en;
            end else if (last_pkt_arrived) begin
                write_pending_hold <= 1'b1;
            end
        end
    end
endmodule

// >>> aicz_regs.vh
// Register map constants for interface configuration register 0.
// Assumes an 8-bit microcontroller data bus with 16-bit addresses.
`ifndef AICZ_REGS_VH
`define AICZ_REGS_VH
`define AICZ_CFG0_ADDR      16'hf0d0
`define AICZ_BCNT0_ADDR     16'hf0d6
`define AICZ_BCNT3_ADDR     16'hf0d9
`define AICZ_CFG0_RESET     8'h00
`define AICZ_CFG0_WMASK     8'h8f
`define AICZ_BIT_VIEW       7
`define AICZ_BIT_WPABORT    3
`define AICZ_BIT_DIRCHK     2
`define AICZ_MODE_PIO       2'h0
`define AICZ_MODE_MWDMA     2'h1
`define AICZ_MODE_RSVD      2'h2
`define AICZ_MODE_UDMA      2'h3
`endif

// >>> aicz_bcnt_mux.v
// Byte count view selector for the four shared read addresses.
// Assumes both counters are held elsewhere and change freely.
`timescale 1ns/1ps
module aicz_bcnt_mux #(
    parameter CW = 32
) (
    input  wire [CW-1:0] usb_count,
    input  wire [CW-1:0] ata_count,
    input  wire          view_sel,
    input  wire [1:0]    byte_idx,
    output reg  [7:0]    rd_byte
);
    reg [CW-1:0] cnt;
    always @* begin
        // Selection affects only the read path, never the counters
        cnt = view_sel ? ata_count : usb_count;
        case (byte_idx) // Lowest address holds the least byte
            2'h0: rd_byte = cnt[7:0];
            2'h1: rd_byte = cnt[15:8];
            2'h2: rd_byte = cnt[23:16];
            default: rd_byte = cnt[31:24];
        endcase
    end
endmodule

// >>> aicz_config0_chk.sv
// Assertion checker for configuration register 0.
// Assumes one mclk domain and a bind by name to aicz_config0.
`timescale 1ns/1ps
module aicz_config0_chk (
    input wire logic mclk, rst_b, wdt_rst, usb_bus_rst, reg_wr, reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [1:0] transfer_protocol_field,
    input wire logic dma_phase_req, xfer_is_atapi, xfer_is_dma, dev_dir_in, bridge_dir_in,
    input wire logic dma_phase_go, xfer_abort, direction_sequence_error_flag,
    input wire logic last_pkt_arrived, mcu_resolve, write_pending_hold, flush_last_pkt, drain_fifo_all
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Shadow of the register, since bits 7:2 have no port
    logic [7:0] cfg_q;
    wire        mism = dma_phase_req & xfer_is_atapi & xfer_is_dma & cfg_q[2] & (dev_dir_in ^ bridge_dir_in);
    always @(posedge mclk) begin
        if (!rst_b || wdt_rst) cfg_q <= 8'h00;
        else if (reg_wr && reg_addr == 16'hf0d0) cfg_q <= reg_wdata & 8'h8f;
    end
    a_mode_follows: assert property (reg_wr && reg_addr == 16'hf0d0 && !wdt_rst |=>
        transfer_protocol_field == $past(reg_wdata[1:0])) else $error("mode field wrong");
    a_wdt_clears: assert property (wdt_rst |=> transfer_protocol_field == 2'h0) else $error("wdt no clear");
    a_usb_keeps: assert property (usb_bus_rst && !reg_wr && !wdt_rst |=>
        $stable(transfer_protocol_field)) else $error("usb reset changed cfg");
    a_read_back: assert property (reg_rd && reg_addr == 16'hf0d0 |=> reg_rdata == $past(cfg_q))
        else $error("read back wrong");
    a_dir_abort: assert property (mism |-> !dma_phase_go ##1 xfer_abort && direction_sequence_error_flag)
        else $error("mismatch not aborted");
    a_ata_pass: assert property (dma_phase_req && !xfer_is_atapi |-> dma_phase_go ##1 !xfer_abort)
        else $error("ata transfer blocked");
    a_hold_set: assert property (last_pkt_arrived |=> write_pending_hold) else $error("no hold");
    a_pend_end: assert property (write_pending_hold && mcu_resolve && !last_pkt_arrived |=>
        !write_pending_hold && flush_last_pkt == $past(cfg_q[3]) && drain_fifo_all == !$past(cfg_q[3]))
        else $error("pending resolve wrong");
endmodule
bind aicz_config0 aicz_config0_chk u_chk (.*);

// >>> tb_top.sv
// Self-checking bench for configuration register 0.
// Assumes aicz_config0 and its checker are compiled first.
`timescale 1ns/1ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
    logic mclk = 0, rst_b = 0, wdt_rst = 0, usb_bus_rst = 0, reg_wr = 0, reg_rd = 0, reg_hit, dma_phase_req = 0;
    logic xfer_is_atapi = 0, xfer_is_dma = 0, dev_dir_in = 0, bridge_dir_in = 0, dma_phase_go, xfer_abort;
    logic direction_sequence_error_flag, dseq_err_clr = 0, last_pkt_arrived = 0, mcu_resolve = 0;
    logic write_pending_hold, flush_last_pkt, drain_fifo_all;
    logic [15:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [1:0] transfer_protocol_field;
    logic [31:0] usb_count = 32'h44332211, ata_count = 32'h88776655;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    aicz_config0 DUT (.*);
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 5000) begin bad_count++; print_verdict; end
    task print_verdict; if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]"); else $display("[ FAIL ]"); $finish; endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; end
        @(posedge mclk) reg_wr <= 0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk) begin reg_addr <= a; reg_rd <= 1; end
        @(posedge mclk) reg_rd <= 0;
        #1 `CK(reg_rdata, e)
        `CK(reg_hit, a == 16'hf0d0 || (a >= 16'hf0d6 && a <= 16'hf0d9))
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_regs;
        for (int m = 0; m < 4; m++) begin wr(16'hf0d0, 8'hf0 | m[7:0]); #1 `CK(transfer_protocol_field, m[1:0]) end
        rd(16'hf0d0, 8'h83);
        rd(16'hf0d1, 8'h00);
        for (int v = 0; v < 2; v++) begin
            // Firmware style update: read, keep bits 6:0, insert the view select
            rd(16'hf0d0, {!v[0], 7'h03});
            wr(16'hf0d0, {v[0], reg_rdata[6:0]});
            #1 `CK(transfer_protocol_field, 2'h3)
            for (int i = 0; i < 4; i++) rd(16'hf0d6 + i[15:0], v ? ata_count[8*i+:8] : usb_count[8*i+:8]);
        end
    endtask
    task t_rst;
        wr(16'hf0d0, 8'h8b);
        @(posedge mclk) usb_bus_rst <= 1;
        @(posedge mclk) usb_bus_rst <= 0;
        rd(16'hf0d0, 8'h8b);
        @(posedge mclk) wdt_rst <= 1;
        @(posedge mclk) wdt_rst <= 0;
        rd(16'hf0d0, 8'h00);
        wr(16'hf0d0, 8'h8b);
        @(posedge mclk) rst_b <= 0;
        @(posedge mclk) rst_b <= 1;
        rd(16'hf0d0, 8'h00);
    endtask
    task t_dir;
        wr(16'hf0d0, 8'h05);
        @(posedge mclk) begin xfer_is_atapi <= 1; xfer_is_dma <= 1; dev_dir_in <= 1; dma_phase_req <= 1; end
        #1 `CK(dma_phase_go, 1'b0)
        @(posedge mclk) begin dma_phase_req <= 0; xfer_is_atapi <= 0; end
        #1 `CK({xfer_abort, direction_sequence_error_flag}, 2'b11)
        @(posedge mclk) begin dseq_err_clr <= 1; dma_phase_req <= 1; end
        #1 `CK(dma_phase_go, 1'b1)
        @(posedge mclk) begin dseq_err_clr <= 0; dma_phase_req <= 0; end
        #1 `CK({xfer_abort, direction_sequence_error_flag}, 2'b00)
    endtask
    task t_wpend;
        for (int b = 1; b >= 0; b--) begin
            wr(16'hf0d0, {4'h0, b[0], 3'h0});
            @(posedge mclk) last_pkt_arrived <= 1;
            @(posedge mclk) last_pkt_arrived <= 0;
            #1 `CK(write_pending_hold, 1'b1)
            @(posedge mclk) mcu_resolve <= 1;
            @(posedge mclk) mcu_resolve <= 0;
            #1 `CK({write_pending_hold, flush_last_pkt, drain_fifo_all}, {1'b0, b[0], !b[0]})
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1;
        t_regs; t_rst; t_dir; t_wpend;
        print_verdict;
    end
endmodule
